//--- include/ufs_pkg.sv
package ufs_pkg;

    // register bus geometry
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [ADDR_W-1:0] DMA_MODE_ADDR = 32'h5000_1194;
    localparam logic [ADDR_W-1:0] FIFO_EN_ADDR  = 32'h5000_1198;
    localparam logic [ADDR_W-1:0] RX_THR_ADDR   = 32'h5000_119c;
    localparam logic [ADDR_W-1:0] TX_THR_ADDR   = 32'h5000_11a0;
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 32'h5000_11b0;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 32'h5000_11b4;

    // field positions inside fifo_control_word
    localparam int FCW_W       = 8;
    localparam int FCW_EN_BIT  = 0;
    localparam int FCW_DMA_BIT = 3;
    localparam int FCW_TX_LSB  = 4;
    localparam int FCW_RX_LSB  = 6;

    // reset values
    localparam logic       DMA_MODE_RST = 1'h0;
    localparam logic       FIFO_EN_RST  = 1'h0;
    localparam logic [1:0] RX_THR_RST   = 2'h0;
    localparam logic [1:0] TX_THR_RST   = 2'h0;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;

    // interrupt status bits
    localparam int ST_W        = 3;
    localparam int ST_RX_AVAIL = 0;
    localparam int ST_TX_EMPTY = 1;
    localparam int ST_FLUSH    = 2;

    // dma signalling modes
    localparam logic DMA_MODE0 = 1'h0;
    localparam logic DMA_MODE1 = 1'h1;

    // threshold codes
    localparam logic [1:0] RX_TRIG_ONE       = 2'h0;
    localparam logic [1:0] RX_TRIG_QUARTER   = 2'h1;
    localparam logic [1:0] RX_TRIG_HALF      = 2'h2;
    localparam logic [1:0] RX_TRIG_NEAR_FULL = 2'h3;
    localparam logic [1:0] TX_TRIG_EMPTY     = 2'h0;
    localparam logic [1:0] TX_TRIG_TWO       = 2'h1;
    localparam logic [1:0] TX_TRIG_QUARTER   = 2'h2;
    localparam logic [1:0] TX_TRIG_HALF      = 2'h3;

    localparam int FIFO_DEPTH_DEF = 16;
    localparam int RX_NEAR_FULL_GAP = 2;
    localparam int TX_TWO_LEVEL     = 2;

    typedef enum logic {BUS_IDLE, BUS_ACK} ufs_bus_state_type;

endpackage : ufs_pkg

//--- include/ufs_thr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ufs_thr_if #(parameter int LW = 5);
    logic [1:0]    rx_code;
    logic [1:0]    tx_code;
    logic [LW-1:0] rx_level;
    logic [LW-1:0] tx_level;

    modport cfg (output rx_code, output tx_code, input rx_level, input tx_level);
    modport dec (input rx_code, input tx_code, output rx_level, output tx_level);
endinterface : ufs_thr_if
`default_nettype wire

//--- design/ufs_trig.sv
`timescale 1ns/1ps
`default_nettype none
module ufs_trig #(
    parameter int DEPTH = 16,
    parameter int LW    = 5
) (
    ufs_thr_if.dec thr
);
    import ufs_pkg::*;

    if (DEPTH < 4 || DEPTH % 4 != 0 || LW < $clog2(DEPTH + 1)) begin : g_chk
        $error("ufs_trig: DEPTH must be a multiple of 4, at least 4");
    end

    function automatic logic [LW-1:0] rx_level_of(input logic [1:0] code);
        logic [LW-1:0] lvl;
        lvl = LW'(1);
        case (code)
            RX_TRIG_ONE:       lvl = LW'(1);
            RX_TRIG_QUARTER:   lvl = LW'(DEPTH / 4);
            RX_TRIG_HALF:      lvl = LW'(DEPTH / 2);
            RX_TRIG_NEAR_FULL: lvl = LW'(DEPTH - RX_NEAR_FULL_GAP);
            default:           lvl = LW'(1);
        endcase
        return lvl;
    endfunction : rx_level_of

    function automatic logic [LW-1:0] tx_level_of(input logic [1:0] code);
        logic [LW-1:0] lvl;
        lvl = '0;
        case (code)
            TX_TRIG_EMPTY:   lvl = '0;
            TX_TRIG_TWO:     lvl = LW'(TX_TWO_LEVEL);
            TX_TRIG_QUARTER: lvl = LW'(DEPTH / 4);
            TX_TRIG_HALF:    lvl = LW'(DEPTH / 2);
            default:         lvl = '0;
        endcase
        return lvl;
    endfunction : tx_level_of

    assign thr.rx_level = rx_level_of(thr.rx_code); // [R06] [R10]
    assign thr.tx_level = tx_level_of(thr.tx_code); // [R09] [R10]

endmodule : ufs_trig
`default_nettype wire

//--- design/ufs_top.sv
// Behaviour
// [R01] A write to the dma mode mirror changes only the dma mode bit and a read returns it.
// [R02] The dma mode bit picks the signalling of the low-active dma requests: 0 mode 0, 1 mode 1; the code uses mode 1 only with the fifos enabled.
// [R03] A write to the fifo enable mirror changes only the enable bit and a read returns it.
// [R04] The enable bit switches both fifos; clearing it after set flushes both fifo controls.
// [R05] A write to the receive threshold mirror changes only its two bits and a read returns them.
// [R06] The receive threshold sets the fill level for data-available: 00 one char, 11 two short of full.
// [R07] In dma mode 1 the receive request asserts at the level the receive threshold selects.
// [R08] A write to the transmit threshold mirror changes only its two bits and a read returns them.
// [R09] In programmable empty mode the transmit threshold sets the empty level: 00 empty, 01 two left.
// [R10] Other codes: receive 01 quarter, 10 half; transmit 10 quarter, 11 half.
`timescale 1ns/1ps
`default_nettype none
module ufs_top #(
    parameter int DEPTH = ufs_pkg::FIFO_DEPTH_DEF,
    parameter int LW    = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       sys_rst,
    // avalon-mm slave
    input  wire logic [ufs_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                       avs_read,
    input  wire logic                       avs_write,
    input  wire logic [ufs_pkg::DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]                 avs_byteenable,
    output logic      [ufs_pkg::DATA_W-1:0] avs_readdata,
    output logic                            avs_waitrequest,
    // uart core side
    input  wire logic [LW-1:0]              rx_fill_count,
    input  wire logic [LW-1:0]              tx_fill_count,
    input  wire logic                       prog_empty_mode,
    output logic      [ufs_pkg::FCW_W-1:0]  fifo_control_word,
    output logic                            fifo_flush,
    output logic                            rx_data_avail,
    output logic                            tx_holding_empty,
    // dma and interrupt
    output logic                            dma_rx_req_n,
    output logic                            dma_tx_req_n,
    output logic                            irq
);
    import ufs_pkg::*;

    if (DEPTH < 4 || DEPTH % 4 != 0 || LW < $clog2(DEPTH + 1)) begin : g_chk
        $error("ufs_top: DEPTH must be a multiple of 4, at least 4");
    end

    ufs_bus_state_type bus_q;
    ufs_bus_state_type bus_d;
    logic              dma_mode_q;
    logic              fifo_en_q;
    logic [1:0]        rx_thr_q;
    logic [1:0]        tx_thr_q;
    logic [ST_W-1:0]   stat_q;
    logic [ST_W-1:0]   stat_d;
    logic [ST_W-1:0]   mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic              flush_q;
    logic              rx_avail_q;
    logic              tx_empty_q;
    logic              rx_req_n_q;
    logic              tx_req_n_q;

    // bus decode
    wire req      = avs_read | avs_write;
    wire commit   = (bus_q == BUS_ACK) && avs_write && avs_byteenable[0];
    wire sel_dma  = (avs_address == DMA_MODE_ADDR);
    wire sel_en   = (avs_address == FIFO_EN_ADDR);
    wire sel_rx   = (avs_address == RX_THR_ADDR);
    wire sel_tx   = (avs_address == TX_THR_ADDR);
    wire sel_stat = (avs_address == IRQ_STAT_ADDR);
    wire sel_mask = (avs_address == IRQ_MASK_ADDR);
    wire wr_dma   = commit && sel_dma;
    wire wr_en    = commit && sel_en;
    wire wr_rx    = commit && sel_rx;
    wire wr_tx    = commit && sel_tx;
    wire wr_stat  = commit && sel_stat;
    wire wr_mask  = commit && sel_mask;

    // single-wait answer: one cycle of waitrequest, then the edge that completes it
    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            BUS_IDLE: if (req) bus_d = BUS_ACK;
            BUS_ACK:  bus_d = BUS_IDLE;
            default:  bus_d = BUS_IDLE;
        endcase
    end

    assign avs_waitrequest = req && (bus_q != BUS_ACK);
    assign avs_readdata    = rdata_q;

    // read mux; unmapped reads give zero
    always_comb begin
        rdata_d = '0;
        if (sel_dma) begin
            rdata_d[0] = dma_mode_q; // [R01]
        end else if (sel_en) begin
            rdata_d[0] = fifo_en_q; // [R03]
        end else if (sel_rx) begin
            rdata_d[1:0] = rx_thr_q; // [R05]
        end else if (sel_tx) begin
            rdata_d[1:0] = tx_thr_q; // [R08]
        end else if (sel_stat) begin
            rdata_d[ST_W-1:0] = stat_q;
        end else if (sel_mask) begin
            rdata_d[ST_W-1:0] = mask_q;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_q   <= BUS_IDLE;
            rdata_q <= '0;
        end else begin
            bus_q <= bus_d;
            if (bus_q == BUS_IDLE && avs_read) rdata_q <= rdata_d;
        end
    end

    // mirrored fields, each written alone
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            dma_mode_q <= DMA_MODE_RST;
            fifo_en_q  <= FIFO_EN_RST;
            rx_thr_q   <= RX_THR_RST;
            tx_thr_q   <= TX_THR_RST;
            mask_q     <= IRQ_MASK_RST;
        end else begin
            if (wr_dma) dma_mode_q <= avs_writedata[0]; // [R01]
            if (wr_en) fifo_en_q <= avs_writedata[0]; // [R03]
            if (wr_rx) rx_thr_q <= avs_writedata[1:0]; // [R05]
            if (wr_tx) tx_thr_q <= avs_writedata[1:0]; // [R08]
            if (wr_mask) mask_q <= avs_writedata[ST_W-1:0];
        end
    end

    always_comb begin
        fifo_control_word = '0;
        fifo_control_word[FCW_EN_BIT]             = fifo_en_q;
        fifo_control_word[FCW_DMA_BIT]            = dma_mode_q;
        fifo_control_word[FCW_TX_LSB +: 2]        = tx_thr_q;
        fifo_control_word[FCW_RX_LSB +: 2]        = rx_thr_q;
    end

    // threshold decode
    ufs_thr_if #(.LW(LW)) thr_bus ();
    ufs_trig #(.DEPTH(DEPTH), .LW(LW)) u_trig (
        .thr (thr_bus)
    );
    assign thr_bus.rx_code = rx_thr_q;
    assign thr_bus.tx_code = tx_thr_q;

    // level conditions; with fifos off only the holding slot counts
    wire en_clear   = wr_en && fifo_en_q && !avs_writedata[0];
    wire rx_at_thr  = (rx_fill_count >= thr_bus.rx_level); // [R06]
    wire rx_any     = (rx_fill_count != '0);
    wire tx_at_thr  = (tx_fill_count <= thr_bus.tx_level); // [R09]
    wire tx_none    = (tx_fill_count == '0);
    wire rx_avail_d = fifo_en_q ? rx_at_thr : rx_any;
    wire tx_empty_d = (fifo_en_q && prog_empty_mode) ? tx_at_thr : tx_none; // [R09]
    wire mode1      = fifo_en_q && (dma_mode_q == DMA_MODE1);
    wire rx_req_d   = mode1 ? rx_at_thr : rx_any; // [R02] [R07]
    wire tx_req_d   = mode1 ? tx_at_thr : tx_none; // [R02]

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flush_q    <= 1'h0;
            rx_avail_q <= 1'h0;
            tx_empty_q <= 1'h0;
            rx_req_n_q <= 1'h1;
            tx_req_n_q <= 1'h1;
        end else begin
            flush_q    <= en_clear; // [R04]
            rx_avail_q <= rx_avail_d;
            tx_empty_q <= tx_empty_d;
            rx_req_n_q <= ~rx_req_d;
            tx_req_n_q <= ~tx_req_d;
        end
    end

    assign fifo_flush       = flush_q;
    assign rx_data_avail    = rx_avail_q;
    assign tx_holding_empty = tx_empty_q;
    assign dma_rx_req_n     = rx_req_n_q;
    assign dma_tx_req_n     = tx_req_n_q;

    // sticky status: set wins over write-one clear
    wire [ST_W-1:0] stat_set = {en_clear, tx_empty_d & ~tx_empty_q, rx_avail_d & ~rx_avail_q};
    wire [ST_W-1:0] stat_clr = wr_stat ? avs_writedata[ST_W-1:0] : '0;
    assign stat_d = (stat_q & ~stat_clr) | stat_set;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) stat_q <= '0;
        else stat_q <= stat_d;
    end

    assign irq = |(stat_q & mask_q);

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_wait;
        req && avs_waitrequest;
    endsequence
    sequence s_done;
        req && !avs_waitrequest;
    endsequence

    bus_answer_a: assert property (s_wait |=> s_done or !req)
        else $error("bus request not answered after one wait cycle");

    dma_mode_wr_a: assert property ( // [R01]
        wr_dma |=> dma_mode_q == $past(avs_writedata[0]) && $stable(fifo_en_q)
            && $stable(rx_thr_q) && $stable(tx_thr_q))
        else $error("dma mode write wrong or disturbed other fields");

    dma_mode_rd_a: assert property ( // [R01]
        bus_q == BUS_IDLE && avs_read && sel_dma |=> avs_readdata == DATA_W'(dma_mode_q))
        else $error("dma mode read back wrong");

    fifo_en_wr_a: assert property ( // [R03]
        wr_en |=> fifo_en_q == $past(avs_writedata[0]) && $stable(dma_mode_q)
            && $stable(rx_thr_q) && $stable(tx_thr_q))
        else $error("fifo enable write wrong");

    sequence s_flush_pulse;
        fifo_flush ##1 !fifo_flush;
    endsequence
    flush_on_clear_a: assert property ($fell(fifo_en_q) |-> s_flush_pulse) // [R04]
        else $error("disabling fifos did not flush once");

    rx_thr_wr_a: assert property ( // [R05]
        wr_rx |=> rx_thr_q == $past(avs_writedata[1:0]) && $stable(tx_thr_q)
            && $stable(fifo_en_q) && $stable(dma_mode_q))
        else $error("receive threshold write wrong");

    tx_thr_wr_a: assert property ( // [R08]
        wr_tx |=> tx_thr_q == $past(avs_writedata[1:0]) && $stable(rx_thr_q)
            && $stable(fifo_en_q) && $stable(dma_mode_q))
        else $error("transmit threshold write wrong");

    rx_one_char_a: assert property ( // [R06]
        fifo_en_q && rx_thr_q == RX_TRIG_ONE && rx_fill_count == LW'(1) |=> rx_data_avail)
        else $error("one character did not raise data available");

    rx_near_full_a: assert property ( // [R06]
        fifo_en_q && rx_thr_q == RX_TRIG_NEAR_FULL
            |-> (rx_fill_count == LW'(DEPTH - 3) |=> !rx_data_avail)
            and (rx_fill_count == LW'(DEPTH - 2) |=> rx_data_avail))
        else $error("near-full receive level wrong");

    rx_half_a: assert property ( // [R10]
        fifo_en_q && rx_thr_q == RX_TRIG_HALF && rx_fill_count == LW'(DEPTH / 2 - 1)
            |=> !rx_data_avail)
        else $error("half receive level wrong");

    dma_rx_mode1_a: assert property ( // [R07]
        mode1 && rx_thr_q == RX_TRIG_HALF
            |-> (rx_fill_count == LW'(DEPTH / 2) |=> !dma_rx_req_n)
            and (rx_fill_count == LW'(DEPTH / 2 - 1) |=> dma_rx_req_n))
        else $error("mode 1 receive request missed its level");

    dma_rx_mode0_a: assert property ( // [R02]
        !mode1 && rx_fill_count == '0 |=> dma_rx_req_n)
        else $error("mode 0 receive request with empty fifo");

    tx_two_left_a: assert property ( // [R09]
        fifo_en_q && prog_empty_mode && tx_thr_q == TX_TRIG_TWO
            |-> (tx_fill_count == LW'(2) |=> tx_holding_empty)
            and (tx_fill_count == LW'(3) |=> !tx_holding_empty))
        else $error("transmit two-left level wrong");

    stat_sticky_a: assert property (stat_q[ST_FLUSH] && !wr_stat |=> stat_q[ST_FLUSH])
        else $error("status bit lost without clear");

endmodule : ufs_top
`default_nettype wire

//--- verification/ufs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ufs_core_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // bench levels
    input  wire logic [4:0] rx_set,
    input  wire logic [4:0] tx_set,
    input  wire logic       pe_set,
    // design side
    input  wire logic       fifo_flush,
    output logic      [4:0] rx_fill_count,
    output logic      [4:0] tx_fill_count,
    output logic            prog_empty_mode
);
    logic [4:0] rx_last_q;
    logic [4:0] tx_last_q;

    // a flush empties both fifos until the bench loads a new level
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_fill_count   <= 5'h0;
            tx_fill_count   <= 5'h0;
            rx_last_q       <= 5'h0;
            tx_last_q       <= 5'h0;
            prog_empty_mode <= 1'h0;
        end else begin
            rx_last_q       <= rx_set;
            tx_last_q       <= tx_set;
            prog_empty_mode <= pe_set;
            if (fifo_flush) begin
                rx_fill_count <= 5'h0;
                tx_fill_count <= 5'h0;
            end else begin
                if (rx_set != rx_last_q) rx_fill_count <= rx_set;
                if (tx_set != tx_last_q) tx_fill_count <= tx_set;
            end
        end
    end
endmodule : ufs_core_model
`default_nettype wire

//--- verification/tb_uart_fifo_ctrl_shadow_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_uart_fifo_ctrl_shadow_regs;
    import ufs_pkg::*;
    localparam int D = 16;
    logic              clk, sys_rst, avs_read, avs_write, prog_empty_mode, pe_set;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, rd;
    logic [3:0]        avs_byteenable;
    logic              avs_waitrequest, fifo_flush, rx_data_avail, tx_holding_empty;
    logic              dma_rx_req_n, dma_tx_req_n, irq;
    logic [4:0]        rx_fill_count, tx_fill_count, rx_set, tx_set;
    logic [FCW_W-1:0]  fifo_control_word;
    int                fail_count, n_compared;
    logic [31:0]       addrs [4] = '{DMA_MODE_ADDR, FIFO_EN_ADDR, RX_THR_ADDR, TX_THR_ADDR};
    logic [31:0]       masks [4] = '{32'h1, 32'h1, 32'h3, 32'h3};
    logic [7:0]        fcw_of [4] = '{8'h08, 8'h01, 8'hc0, 8'h30};
    int                rx_lv [4] = '{1, D / 4, D / 2, D - RX_NEAR_FULL_GAP};
    int                tx_lv [4] = '{0, TX_TWO_LEVEL, D / 4, D / 2};

    ufs_top #(.DEPTH(D)) i_dut (
        .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_fill_count,
        .tx_fill_count, .prog_empty_mode, .fifo_control_word, .fifo_flush,
        .rx_data_avail, .tx_holding_empty, .dma_rx_req_n, .dma_tx_req_n, .irq
    );
    ufs_core_model i_core (
        .clk, .sys_rst, .rx_set, .tx_set, .pe_set, .fifo_flush,
        .rx_fill_count, .tx_fill_count, .prog_empty_mode
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    // one avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= wr;
        avs_read       <= !wr;
        // no cycle count assumed; only the watchdog ends a hung wait
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : bus

    task automatic lv(input int r, input int t, input logic p);
        @(posedge clk);
        rx_set <= 5'(r);
        tx_set <= 5'(t);
        pe_set <= p;
        repeat (3) @(negedge clk);
    endtask : lv

    task close_out;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out

    initial begin
        #(100 * 5000);
        fail_count++;
        close_out;
    end

    initial begin
        sys_rst <= 1'b1;
        {avs_read, avs_write, pe_set} <= 3'h0;
        avs_address <= 32'h0;
        avs_writedata <= 32'h0;
        avs_byteenable <= 4'hf;
        {rx_set, tx_set} <= 10'h0;
        fail_count = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, addrs[i], 32'h0, 4'hf);
            chk_word(rd, 32'h0);
        end
        bus(1'b0, IRQ_MASK_ADDR, 32'h0, 4'hf);
        chk_word(rd, 32'h0);
        bus(1'b0, 32'h5000_11a8, 32'h0, 4'hf);
        chk_word(rd, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, addrs[i], 32'hffff_ffff, 4'hf);
            @(negedge clk);
            chk_word({24'h0, fifo_control_word}, {24'h0, fcw_of[i]});
            bus(1'b0, addrs[i], 32'h0, 4'hf);
            chk_word(rd, masks[i]);
            bus(1'b1, addrs[i], 32'h0, 4'hf);
        end
        bus(1'b1, RX_THR_ADDR, 32'h3, 4'h0);
        bus(1'b0, RX_THR_ADDR, 32'h0, 4'hf);
        chk_word(rd, 32'h0);
        $display("field isolation done");
        bus(1'b1, FIFO_EN_ADDR, 32'h1, 4'hf);
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, RX_THR_ADDR, 32'(c), 4'hf);
            lv(rx_lv[c] - 1, 1, 1'b0);
            chk_bit(rx_data_avail, 1'b0);
            lv(rx_lv[c], 1, 1'b0);
            chk_bit(rx_data_avail, 1'b1);
            bus(1'b1, TX_THR_ADDR, 32'(c), 4'hf);
            lv(0, tx_lv[c] + 1, 1'b1);
            chk_bit(tx_holding_empty, 1'b0);
            lv(0, tx_lv[c], 1'b1);
            chk_bit(tx_holding_empty, 1'b1);
        end
        bus(1'b1, TX_THR_ADDR, 32'h1, 4'hf);
        lv(0, 2, 1'b0);
        chk_bit(tx_holding_empty, 1'b0);
        $display("thresholds done");
        bus(1'b1, DMA_MODE_ADDR, 32'h1, 4'hf);
        bus(1'b1, RX_THR_ADDR, 32'h2, 4'hf);
        bus(1'b1, TX_THR_ADDR, 32'h3, 4'hf);
        lv(D / 2 - 1, 5, 1'b0);
        chk_bit(dma_rx_req_n, 1'b1);
        chk_bit(dma_tx_req_n, 1'b0);
        lv(D / 2, 5, 1'b0);
        chk_bit(dma_rx_req_n, 1'b0);
        bus(1'b1, DMA_MODE_ADDR, 32'h0, 4'hf);
        lv(D / 2 - 1, 5, 1'b0);
        chk_bit(dma_rx_req_n, 1'b0);
        chk_bit(dma_tx_req_n, 1'b1);
        $display("dma modes done");
        bus(1'b1, IRQ_MASK_ADDR, 32'h4, 4'hf);
        bus(1'b1, IRQ_STAT_ADDR, 32'h7, 4'hf);
        lv(5, 5, 1'b0);
        chk_bit(irq, 1'b0);
        bus(1'b1, FIFO_EN_ADDR, 32'h0, 4'hf);
        @(negedge clk);
        chk_bit(fifo_flush, 1'b1);
        chk_bit(fifo_control_word[FCW_EN_BIT], 1'b0);
        @(negedge clk);
        chk_bit(fifo_flush, 1'b0);
        repeat (3) @(negedge clk);
        chk_bit(rx_data_avail, 1'b0);
        chk_bit(irq, 1'b1);
        bus(1'b0, IRQ_STAT_ADDR, 32'h0, 4'hf);
        chk_bit(rd[ST_FLUSH], 1'b1);
        bus(1'b1, IRQ_STAT_ADDR, 32'h4, 4'hf);
        @(negedge clk);
        chk_bit(irq, 1'b0);
        bus(1'b1, FIFO_EN_ADDR, 32'h0, 4'hf);
        @(negedge clk);
        chk_bit(fifo_flush, 1'b0);
        $display("flush and interrupt done");
        close_out;
    end
endmodule : tb_uart_fifo_ctrl_shadow_regs
`default_nettype wire
